// File: design/tws_defs.vh
// Constants for the two-wire serial master/slave controller
//
// Summary of operation
// - Bus busy flag reads zero while the shared bus is free.
// - Setting master and transmit bits, then writing data, sends START and address.
// - Hardware waits the bus free time after STOP before its own START.
// - Each finished byte sets both the byte done flag and the pending flag.
// - Interrupt output follows pending flag gated by the interrupt enable bit.
// - Pending flag clears only when software writes one to its status bit.
// - Byte done clears on data read in receive or data write in transmit.
// - After the master address byte the block stays in transmit mode.
// - Slave direction flag is meaningful only at slave address cycles.
// - Clearing the master bit while master generates a STOP condition.
// - Ack disable bit makes the master receiver withhold its acknowledge.
// - Repeated start bit makes the master send START again, then new address.
// - Addressed flag sets on own address match, clears on any control write.
// - An addressed slave holds the clock low between bytes until data access.
// - Received acknowledge is reported; slave transmitter ends by dummy read.
// - Lost arbitration turns slave receive, clocks out the byte, then interrupts.
// - START attempted on a busy bus fails: master bit clears, arbitration lost set.
// - Arbitration lost, byte done and address match share one interrupt.
// - Master sending one while the line reads zero loses arbitration.
// - The receiver pulls data low on the ninth clock to acknowledge.
`ifndef TWS_DEFS_VH
`define TWS_DEFS_VH

`define TWS_A_OWN 3'h0
`define TWS_A_DIV 3'h1
`define TWS_A_CTL 3'h2
`define TWS_A_STS 3'h3
`define TWS_A_DAT 3'h4

`define TWS_C_IEN 6
`define TWS_C_MSEL 5
`define TWS_C_TX 4
`define TWS_C_ACK_DISABLE_BIT 3
`define TWS_C_RSTA 2

`define TWS_S_TCF 7
`define TWS_S_AAS 6
`define TWS_S_BB 5
`define TWS_S_AL 4
`define TWS_S_SRW 2
`define TWS_S_IF 1
`define TWS_S_RECEIVED_ACK_FLAG 0

`define TWS_OWN_RST 7'h00
`define TWS_DIV_RST 8'h20
`define TWS_HALF_MIN 8'h08

`define TWS_CLK_NS 50
`define TWS_TBUF_NS 5000
`define TWS_TBUF_CYC ((`TWS_TBUF_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)

`endif

// File: design/tws_ctrl.v
// Two-wire serial master/slave controller
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "tws_defs.vh"

module tws_ctrl (
	// System
	input wire clock,
	input wire reset,
	// Register port
	input wire [2:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output wire [7:0] reg_rdata,
	// Bus pins, open drain
	input wire scl_in,
	output wire scl_out,
	output wire scl_oe,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe,
	// Interrupt
	output wire irq
);

localparam [6:0] S_IDLE = 7'h01;
localparam [6:0] S_BUF = 7'h02;
localparam [6:0] S_STA = 7'h04;
localparam [6:0] S_RUN = 7'h08;
localparam [6:0] S_HOLD = 7'h10;
localparam [6:0] S_STP = 7'h20;
localparam [6:0] S_RS = 7'h40;
localparam [31:0] TBUF_W = `TWS_TBUF_CYC;
localparam [15:0] TBUF = TBUF_W[15:0];

function sel;
	input [2:0] a;
	input [2:0] idx;
	begin
		sel = (a == idx);
	end
endfunction

reg scl_s1_ff, scl_s2_ff, scl_s3_ff, scl_f_ff, scl_fp_ff;
reg sda_s1_ff, sda_s2_ff, sda_s3_ff, sda_f_ff, sda_fp_ff;
reg scl_oe_ff, sda_oe_ff, irq_ff, zero_ff;
reg [7:0] rdata_ff;
reg [6:0] own_ff;
reg [7:0] div_ff, dat_ff, sh_ff, tm_ff;
reg ien_ff, msel_ff, tx_ff, ack_disable_bit_ff, rs_ff, go_ff;
reg tcf_ff, aas_ff, bb_ff, al_ff, srw_ff, if_ff, received_ack_flag_ff;
reg [15:0] free_ff;
reg act_ff, adr_ff, etx_ff, mine_ff, slv_ff, hit_ff, lost_ff;
reg hold_ff, str_ff, esda_ff, mscl_ff, msda_ff;
reg [3:0] cnt_ff;
reg [6:0] st_ff;
reg [1:0] ph_ff;

wire wr_ctl = reg_wr & sel(reg_addr, `TWS_A_CTL);
wire wr_sts = reg_wr & sel(reg_addr, `TWS_A_STS);
wire wr_dat = reg_wr & sel(reg_addr, `TWS_A_DAT);
wire rd_dat = reg_rd & sel(reg_addr, `TWS_A_DAT);
wire scl_rise = scl_f_ff & ~scl_fp_ff;
wire scl_fall = ~scl_f_ff & scl_fp_ff;
wire sta_det = scl_f_ff & scl_fp_ff & sda_fp_ff & ~sda_f_ff;
wire stp_det = scl_f_ff & scl_fp_ff & ~sda_fp_ff & sda_f_ff;
wire tdone = (tm_ff == 8'h00);
// Short half periods would outrun the pin synchroniser
wire [7:0] half = (div_ff < `TWS_HALF_MIN) ? `TWS_HALF_MIN : div_ff;
wire [7:0] tm_dec = tm_ff - 8'h01;
wire access = (wr_dat & tx_ff) | (rd_dat & ~tx_ff);
wire kick = hold_ff & access & ~(mine_ff & rs_ff);
wire own_sta = (st_ff == S_STA) | (st_ff == S_RS);
wire [7:0] ctl_rd = {1'b0, ien_ff, msel_ff, tx_ff, ack_disable_bit_ff, 3'b000};
wire [7:0] sts_rd = {tcf_ff, aas_ff, bb_ff, al_ff, 1'b0, srw_ff, if_ff, received_ack_flag_ff};

assign reg_rdata = rdata_ff;
assign scl_out = zero_ff;
assign sda_out = zero_ff;
assign scl_oe = scl_oe_ff;
assign sda_oe = sda_oe_ff;
assign irq = irq_ff;

always @(posedge clock or posedge reset)
begin
	if (reset)
	begin
		scl_s1_ff <= 1'b1;
		scl_s2_ff <= 1'b1;
		scl_s3_ff <= 1'b1;
		scl_f_ff <= 1'b1;
		scl_fp_ff <= 1'b1;
		sda_s1_ff <= 1'b1;
		sda_s2_ff <= 1'b1;
		sda_s3_ff <= 1'b1;
		sda_f_ff <= 1'b1;
		sda_fp_ff <= 1'b1;
		scl_oe_ff <= 1'b0;
		sda_oe_ff <= 1'b0;
		irq_ff <= 1'b0;
		zero_ff <= 1'b0;
		rdata_ff <= 8'h00;
		own_ff <= `TWS_OWN_RST;
		div_ff <= `TWS_DIV_RST;
		dat_ff <= 8'h00;
		sh_ff <= 8'h00;
		tm_ff <= 8'h00;
		ien_ff <= 1'b0;
		msel_ff <= 1'b0;
		tx_ff <= 1'b0;
		ack_disable_bit_ff <= 1'b0;
		rs_ff <= 1'b0;
		go_ff <= 1'b0;
		tcf_ff <= 1'b1;
		aas_ff <= 1'b0;
		bb_ff <= 1'b0;
		al_ff <= 1'b0;
		srw_ff <= 1'b0;
		if_ff <= 1'b0;
		received_ack_flag_ff <= 1'b0;
		free_ff <= 16'h0000;
		act_ff <= 1'b0;
		adr_ff <= 1'b0;
		etx_ff <= 1'b0;
		mine_ff <= 1'b0;
		slv_ff <= 1'b0;
		hit_ff <= 1'b0;
		lost_ff <= 1'b0;
		hold_ff <= 1'b0;
		str_ff <= 1'b0;
		esda_ff <= 1'b0;
		mscl_ff <= 1'b0;
		msda_ff <= 1'b0;
		cnt_ff <= 4'h0;
		st_ff <= S_IDLE;
		ph_ff <= 2'b00;
	end
	else
	begin
		// Three-stage pin sampling, change taken when stages agree
		scl_s1_ff <= scl_in;
		scl_s2_ff <= scl_s1_ff;
		scl_s3_ff <= scl_s2_ff;
		if (scl_s2_ff == scl_s3_ff)
			scl_f_ff <= scl_s3_ff;
		scl_fp_ff <= scl_f_ff;
		sda_s1_ff <= sda_in;
		sda_s2_ff <= sda_s1_ff;
		sda_s3_ff <= sda_s2_ff;
		if (sda_s2_ff == sda_s3_ff)
			sda_f_ff <= sda_s3_ff;
		sda_fp_ff <= sda_f_ff;
		// Master and slave each pull low; either one wins the wire
		scl_oe_ff <= mscl_ff | str_ff;
		sda_oe_ff <= msda_ff | esda_ff;
		irq_ff <= ien_ff & if_ff;

		rdata_ff <= 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				`TWS_A_OWN: rdata_ff <= {own_ff, 1'b0};
				`TWS_A_DIV: rdata_ff <= div_ff;
				`TWS_A_CTL: rdata_ff <= ctl_rd;
				`TWS_A_STS: rdata_ff <= sts_rd;
				`TWS_A_DAT: rdata_ff <= dat_ff;
				default: rdata_ff <= 8'h00;
			endcase
		end

		if (reg_wr & sel(reg_addr, `TWS_A_OWN))
			own_ff <= reg_wdata[7:1];
		if (reg_wr & sel(reg_addr, `TWS_A_DIV))
			div_ff <= reg_wdata;
		if (wr_ctl)
		begin
			ien_ff <= reg_wdata[`TWS_C_IEN];
			tx_ff <= reg_wdata[`TWS_C_TX];
			ack_disable_bit_ff <= reg_wdata[`TWS_C_ACK_DISABLE_BIT];
			msel_ff <= reg_wdata[`TWS_C_MSEL];
			aas_ff <= 1'b0;
			if (reg_wdata[`TWS_C_RSTA] & msel_ff)
				rs_ff <= 1'b1;
			if (reg_wdata[`TWS_C_MSEL] & ~msel_ff & bb_ff)
			begin
				msel_ff <= 1'b0;
				al_ff <= 1'b1;
				if_ff <= 1'b1;
			end
		end
		if (wr_sts)
		begin
			if (reg_wdata[`TWS_S_IF])
				if_ff <= 1'b0;
			if (reg_wdata[`TWS_S_AL])
				al_ff <= 1'b0;
		end
		if (wr_dat)
		begin
			dat_ff <= reg_wdata;
			if (msel_ff & ((st_ff == S_IDLE) | rs_ff))
				go_ff <= 1'b1;
		end
		if (access)
			tcf_ff <= 1'b0;

		if (sta_det)
			bb_ff <= 1'b1;
		if (stp_det)
			bb_ff <= 1'b0;
		if (bb_ff)
			free_ff <= 16'h0000;
		else if (free_ff < TBUF)
			free_ff <= free_ff + 16'h0001;

		// data access restarts the byte and frees the clock
		if (kick)
		begin
			act_ff <= 1'b1;
			adr_ff <= 1'b0;
			cnt_ff <= 4'h0;
			etx_ff <= tx_ff;
			hold_ff <= 1'b0;
			str_ff <= 1'b0;
			esda_ff <= tx_ff & ~reg_wdata[7];
			if (tx_ff)
				sh_ff <= reg_wdata;
		end
		if (sta_det)
		begin
			act_ff <= 1'b1;
			adr_ff <= 1'b1;
			cnt_ff <= 4'h0;
			hold_ff <= 1'b0;
			str_ff <= 1'b0;
			esda_ff <= 1'b0;
			slv_ff <= 1'b0;
			hit_ff <= 1'b0;
			mine_ff <= own_sta;
			etx_ff <= own_sta;
			if (own_sta)
				sh_ff <= dat_ff;
		end
		else if (stp_det)
		begin
			act_ff <= 1'b0;
			hold_ff <= 1'b0;
			str_ff <= 1'b0;
			esda_ff <= 1'b0;
			slv_ff <= 1'b0;
			mine_ff <= 1'b0;
		end
		else if (act_ff & scl_rise)
		begin
			cnt_ff <= cnt_ff + 4'h1;
			// ninth bit is the received acknowledge
			if (cnt_ff[3])
				received_ack_flag_ff <= sda_f_ff;
			else
				sh_ff <= {sh_ff[6:0], sda_f_ff};
			if (~cnt_ff[3] & mine_ff & etx_ff & sh_ff[7] & ~sda_f_ff)
			begin
				mine_ff <= 1'b0;
				etx_ff <= 1'b0;
				esda_ff <= 1'b0;
				msel_ff <= 1'b0;
				tx_ff <= 1'b0;
				al_ff <= 1'b1;
				lost_ff <= 1'b1;
			end
			if ((cnt_ff == 4'h7) & adr_ff & ~mine_ff & (sh_ff[6:0] == own_ff))
			begin
				hit_ff <= 1'b1;
				slv_ff <= 1'b1;
				srw_ff <= sda_f_ff;
			end
		end
		else if (act_ff & scl_fall)
		begin
			if (cnt_ff == 4'h9)
			begin
				act_ff <= 1'b0;
				esda_ff <= 1'b0;
				hit_ff <= 1'b0;
				lost_ff <= 1'b0;
				if (mine_ff | slv_ff | lost_ff)
				begin
					tcf_ff <= 1'b1;
					if_ff <= 1'b1;
					dat_ff <= sh_ff;
				end
				if (mine_ff | slv_ff)
					hold_ff <= 1'b1;
				if (slv_ff & ~mine_ff)
					str_ff <= 1'b1;
				if (hit_ff)
					aas_ff <= 1'b1;
			end
			else if (cnt_ff[3])
				esda_ff <= ~etx_ff & (adr_ff ? hit_ff : ((mine_ff | slv_ff) & ~ack_disable_bit_ff));
			else
				esda_ff <= etx_ff & ~sh_ff[7];
		end

		case (st_ff)
			S_IDLE:
			begin
				mscl_ff <= 1'b0;
				msda_ff <= 1'b0;
				ph_ff <= 2'b00;
				if (~msel_ff)
					go_ff <= 1'b0;
				else if (go_ff)
					st_ff <= S_BUF;
			end
			S_BUF:
			begin
				// another master took the bus first
				if (bb_ff)
				begin
					msel_ff <= 1'b0;
					al_ff <= 1'b1;
					if_ff <= 1'b1;
					go_ff <= 1'b0;
					st_ff <= S_IDLE;
				end
				else if (free_ff >= TBUF)
				begin
					msda_ff <= 1'b1;
					tm_ff <= half;
					st_ff <= S_STA;
				end
			end
			S_STA:
			begin
				if (tdone)
				begin
					mscl_ff <= 1'b1;
					tm_ff <= half;
					go_ff <= 1'b0;
					st_ff <= S_RUN;
				end
				else
					tm_ff <= tm_dec;
			end
			S_RUN:
			begin
				// Hand data line to the shifter only once clock is low
				if (~scl_f_ff)
					msda_ff <= 1'b0;
				// lost byte finished, drop the clock
				if (~mine_ff & ~act_ff)
				begin
					mscl_ff <= 1'b0;
					st_ff <= S_IDLE;
				end
				else if (mscl_ff)
				begin
					if (~tdone)
						tm_ff <= tm_dec;
					else if (hold_ff)
						st_ff <= S_HOLD;
					else
					begin
						mscl_ff <= 1'b0;
						tm_ff <= half;
					end
				end
				// High time counts only once the wire is high
				else if (scl_f_ff)
				begin
					if (~tdone)
						tm_ff <= tm_dec;
					else
					begin
						mscl_ff <= 1'b1;
						tm_ff <= half;
					end
				end
			end
			S_HOLD:
			begin
				tm_ff <= half;
				ph_ff <= 2'b00;
				if (~msel_ff)
					st_ff <= S_STP;
				else if (rs_ff & go_ff)
					st_ff <= S_RS;
				else if (~hold_ff)
					st_ff <= S_RUN;
			end
			S_STP:
			begin
				if (ph_ff == 2'b00)
				begin
					msda_ff <= 1'b1;
					if (tdone)
					begin
						mscl_ff <= 1'b0;
						tm_ff <= half;
						ph_ff <= 2'b01;
					end
					else
						tm_ff <= tm_dec;
				end
				else if (scl_f_ff)
				begin
					if (tdone)
					begin
						msda_ff <= 1'b0;
						st_ff <= S_IDLE;
					end
					else
						tm_ff <= tm_dec;
				end
			end
			S_RS:
			begin
				// release data, raise clock, then START
				if (ph_ff == 2'b00)
				begin
					msda_ff <= 1'b0;
					if (tdone)
					begin
						mscl_ff <= 1'b0;
						tm_ff <= half;
						ph_ff <= 2'b01;
					end
					else
						tm_ff <= tm_dec;
				end
				else if (ph_ff == 2'b01)
				begin
					if (scl_f_ff & tdone)
					begin
						msda_ff <= 1'b1;
						tm_ff <= half;
						ph_ff <= 2'b10;
					end
					else if (scl_f_ff)
						tm_ff <= tm_dec;
				end
				else if (tdone)
				begin
					mscl_ff <= 1'b1;
					tm_ff <= half;
					rs_ff <= 1'b0;
					go_ff <= 1'b0;
					st_ff <= S_RUN;
				end
				else
					tm_ff <= tm_dec;
			end
			default: st_ff <= S_IDLE;
		endcase
	end
end

endmodule // tws_ctrl
`default_nettype wire

// File: dv/tws_ctrl_monitor.sv
// Port checker for the two-wire controller
`timescale 1ns/1ps
`default_nettype none
module tws_ctrl_chk (
	// System
	input wire logic clock,
	input wire logic reset,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Bus pins
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// Interrupt
	input wire logic irq
);
	logic idle_ff;
	logic prev_sda_ff;
	logic [7:0] free_ff;
	default clocking @(posedge clock);
	endclocking
	default disable iff (reset);
	// Bus free tracking from raw wires
	always_ff @(posedge clock or posedge reset)
		if (reset)
		begin
			idle_ff <= 1'b1;
			prev_sda_ff <= 1'b1;
			free_ff <= 8'hff;
		end
		else
		begin
			prev_sda_ff <= sda_in;
			if (free_ff != 8'hff)
				free_ff <= free_ff + 8'h01;
			if (scl_in && sda_in && !prev_sda_ff)
			begin
				idle_ff <= 1'b1;
				free_ff <= 8'h00;
			end
			else if (scl_in && !sda_in && prev_sda_ff)
				idle_ff <= 1'b0;
		end
	property p_pins_od;
		sda_out == 1'b0 && scl_out == 1'b0;
	endproperty
	a_pins_od: assert property (p_pins_od) else $error("pin driven high");
	property p_rdata_idle;
		!$past(reg_rd) |-> reg_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
	property p_irq_fall;
		$fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");
	property p_irq_rise;
		$rose(irq) |-> $past(reg_wr, 2) || $past(reg_wr, 3) || !scl_in;
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
	property p_free;
		$rose(sda_oe) && idle_ff |-> free_ff >= 8'h64;
	endproperty
	a_free: assert property (p_free) else $error("start too soon after stop");
	property p_start_hold;
		$rose(sda_oe) && idle_ff |-> !scl_oe [*8];
	endproperty
	a_start_hold: assert property (p_start_hold) else $error("start not formed");
	property p_start_clk;
		$rose(sda_oe) && idle_ff |-> ##[8:600] scl_oe;
	endproperty
	a_start_clk: assert property (p_start_clk) else $error("no clock after start");
	property p_idle_quiet;
		idle_ff && !sda_oe |-> !scl_oe;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("clock driven on free bus");
endmodule // tws_ctrl_chk

bind tws_ctrl tws_ctrl_chk chk_u (.clock(clock), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
`default_nettype wire

// File: dv/tws_slave_model.sv
// Behavioural slave device on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module tws_slave_model #(
	parameter logic [6:0] DEV_ADDR = 7'h2a,
	parameter logic [7:0] TX_BYTE = 8'hc5
) (
	// Bus wires
	input wire logic scl,
	input wire logic sda,
	input wire logic slow,
	// Pulls, high drives low
	output logic scl_pull,
	output logic sda_pull,
	output logic [7:0] rx_byte
);
	logic [7:0] sh = 8'h00;
	logic sel = 1'b0;
	logic rd = 1'b0;
	logic adr = 1'b0;
	int n = 0;
	initial
	begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
		rx_byte = 8'h00;
	end
	always @(negedge sda)
		if (scl)
		begin
			adr = 1'b1;
			sel = 1'b0;
			n = 0;
		end
	always @(posedge sda)
		if (scl)
			sel = 1'b0;
	always @(posedge scl)
		if (n < 8)
		begin
			sh = {sh[6:0], sda};
			n = n + 1;
		end
		else if (sel && rd && !adr && sda)
			sel = 1'b0;
	always @(negedge scl)
		if (n == 8)
		begin
			if (adr)
			begin
				sel = sh[7:1] == DEV_ADDR;
				rd = sh[0];
			end
			else if (sel && !rd)
				rx_byte = sh;
			sda_pull = sel && (adr || !rd);
			n = 9;
		end
		else if (n == 9)
		begin
			adr = 1'b0;
			n = 0;
			sda_pull = sel && rd && !TX_BYTE[7];
			// Stretch keeps the master waiting
			if (slow)
			begin
				scl_pull = 1'b1;
				#700;
				scl_pull = 1'b0;
			end
		end
		else if (sel && rd)
			sda_pull = !TX_BYTE[7 - n];
endmodule // tws_slave_model
`default_nettype wire

// File: dv/tws_ctrl_tb.sv
// Self-checking bench for the two-wire controller
`timescale 1ns/1ps
`default_nettype none
module tws_ctrl_tb;
	localparam logic [6:0] SL = 7'h2a;
	logic clock, reset, reg_wr, reg_rd, other_sda, other_scl, slow, ack;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, d, dat;
	logic [6:0] own;
	wire [7:0] reg_rdata, rx_byte;
	wire scl_out, scl_oe, sda_out, sda_oe, irq, sl_scl, sl_sda;
	wire scl_w = !(scl_oe | sl_scl | other_scl);
	wire sda_w = !(sda_oe | sl_sda | other_sda);
	int failures = 0;
	int checked = 0;
	tws_ctrl dut_u (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_w), .scl_out(scl_out),
		.scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
	tws_slave_model #(.DEV_ADDR(SL), .TX_BYTE(8'hc5)) sl_u (.scl(scl_w), .sda(sda_w), .slow(slow),
		.scl_pull(sl_scl), .sda_pull(sl_sda), .rx_byte(rx_byte));
	function automatic logic [7:0] st(logic byte_done_flag, logic bb, logic al, logic ifl, logic nak);
		return {byte_done_flag, 1'b0, bb, al, 2'b00, ifl, nak};
	endfunction
	task close_out;
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task wait_st(input int b, input logic v);
		for (int i = 0; i < 3000; i++)
		begin
			rd(3'h3, d);
			if (d[b] === v)
				return;
		end
		failures++;
		$display("unexpected at %0t: status wait ran out", $time);
		close_out();
	endtask
	// Far master clocks one byte plus the ack slot; low time leaves room for our synchroniser
	task xbyte(input logic [7:0] b, output logic ab);
		for (int i = 8; i >= 0; i--)
		begin
			other_scl <= 1'b1;
			repeat (2) @(posedge clock);
			other_sda <= (i > 0) ? !b[i - 1] : 1'b0;
			repeat (6) @(posedge clock);
			other_scl <= 1'b0;
			repeat (4) @(posedge clock);
			ab = sda_w;
		end
		other_scl <= 1'b1;
	endtask
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial
	begin
		{reset, reg_addr, reg_wdata, reg_wr, reg_rd, other_sda, other_scl, slow} <= 17'h1_0000;
		void'($urandom(32'h846b_06fb));
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		repeat (4) @(posedge clock);
		wr(3'h7, 8'h5a);
		for (int a = 0; a < 8; a++)
		begin
			rd(a[2:0], d);
			chk(d, a == 1 ? 8'h20 : a == 3 ? 8'h80 : 8'h00);
		end
		own = 7'($urandom);
		// Zero would match the all-zero address of the lost byte
		if (own == 7'h00 || own[6:1] == SL[6:1])
			own = 7'h11;
		wr(3'h0, {own, 1'b0});
		wr(3'h1, 8'h08);
		rd(3'h0, d);
		chk(d, {own, 1'b0});
		wr(3'h2, 8'h30);
		wr(3'h4, {SL, 1'b0});
		wait_st(5, 1'b1);
		wait_st(1, 1'b1);
		rd(3'h3, d);
		chk(d, st(1, 1, 0, 1, 0));
		chk({7'h00, irq}, 8'h00);
		wr(3'h2, 8'h70);
		repeat (2) @(posedge clock);
		#1 chk({7'h00, irq}, 8'h01);
		wr(3'h3, 8'h00);
		rd(3'h3, d);
		chk(d, st(1, 1, 0, 1, 0));
		wr(3'h3, 8'h02);
		rd(3'h3, d);
		chk(d, st(1, 1, 0, 0, 0));
		chk({7'h00, irq}, 8'h00);
		dat = 8'($urandom);
		slow = 1'b1;
		wr(3'h4, dat);
		rd(3'h3, d);
		chk(d, st(0, 1, 0, 0, 0));
		wait_st(1, 1'b1);
		chk(rx_byte, dat);
		wr(3'h3, 8'h02);
		wr(3'h2, 8'h00);
		wait_st(5, 1'b0);
		rd(3'h3, d);
		chk(d, st(1, 0, 0, 0, 0));
		slow = 1'b0;
		wr(3'h2, 8'h30);
		wr(3'h4, {SL, 1'b1});
		wait_st(1, 1'b1);
		rd(3'h2, d);
		chk(d, 8'h30);
		wr(3'h3, 8'h02);
		wr(3'h2, 8'h28);
		rd(3'h4, d);
		wait_st(1, 1'b1);
		wr(3'h3, 8'h02);
		wr(3'h2, 8'h00);
		rd(3'h4, d);
		chk(d, 8'hc5);
		wait_st(5, 1'b0);
		wr(3'h2, 8'h30);
		wr(3'h4, {SL ^ 7'h01, 1'b0});
		wait_st(1, 1'b1);
		rd(3'h3, d);
		chk(d, st(1, 1, 0, 1, 1));
		wr(3'h3, 8'h02);
		wr(3'h2, 8'h34);
		wr(3'h4, {SL, 1'b0});
		wait_st(1, 1'b1);
		rd(3'h3, d);
		chk(d, st(1, 1, 0, 1, 0));
		wr(3'h3, 8'h02);
		wr(3'h2, 8'h00);
		wait_st(5, 1'b0);
		wr(3'h2, 8'h30);
		wr(3'h4, 8'hfe);
		wait_st(5, 1'b1);
		// Far master holds data low, so our first one bit loses
		other_sda <= 1'b1;
		wait_st(1, 1'b1);
		rd(3'h3, d);
		chk(d, st(1, 1, 1, 1, 0));
		rd(3'h2, d);
		chk(d, 8'h00);
		wr(3'h3, 8'h12);
		repeat (4) @(posedge clock);
		other_sda <= 1'b0;
		wait_st(5, 1'b0);
		other_sda <= 1'b1;
		wait_st(5, 1'b1);
		wr(3'h2, 8'h30);
		rd(3'h2, d);
		chk(d & 8'h20, 8'h00);
		rd(3'h3, d);
		chk(d, st(1, 1, 1, 1, 0));
		wr(3'h3, 8'h12);
		rd(3'h3, d);
		chk(d, st(1, 1, 0, 0, 0));
		other_sda <= 1'b0;
		wait_st(5, 1'b0);
		// Far master calls our own address for a read
		@(posedge clock);
		other_sda <= 1'b1;
		repeat (6) @(posedge clock);
		xbyte({own, 1'b1}, ack);
		chk({7'h00, ack}, 8'h00);
		repeat (12) @(posedge clock);
		other_scl <= 1'b0;
		repeat (8) @(posedge clock);
		#1 chk({7'h00, scl_oe}, 8'h01);
		rd(3'h3, d);
		chk(d, st(1, 1, 0, 1, 0) | 8'h44);
		wr(3'h2, 8'h00);
		rd(3'h3, d);
		chk(d, st(1, 1, 0, 1, 0) | 8'h04);
		chk({7'h00, scl_oe}, 8'h01);
		rd(3'h4, d);
		chk(d, {own, 1'b1});
		@(posedge clock);
		#1 chk({7'h00, scl_oe}, 8'h00);
		other_scl <= 1'b1;
		repeat (2) @(posedge clock);
		other_sda <= 1'b1;
		repeat (4) @(posedge clock);
		other_scl <= 1'b0;
		repeat (4) @(posedge clock);
		other_sda <= 1'b0;
		wait_st(5, 1'b0);
		close_out();
	end
endmodule // tws_ctrl_tb
`default_nettype wire
